// ---- core/mszc_pkg.sv ----
// Function
// - size register written as one byte
// - expansion size register written as one byte
// - reset loads size register with cfh
// - reset loads expansion register with 0ch
// - bits 7..5 pick fast ram size
// - bits 3..0 pick rom size
// - bits 4..0 pick expansion ram size
// - clocked serial programming uses internal oscillator
// - async serial programming uses crystal or external clock
// - mode pin low normal, high programming
package mszc_pkg;
	localparam logic [15:0] MSZC_MEM_SIZE_ADDR = 16'hfff0;
	localparam logic [15:0] MSZC_XRAM_SIZE_ADDR = 16'hfff4;
	localparam logic [7:0] MSZC_MEM_SIZE_RESET = 8'hcf;
	localparam logic [7:0] MSZC_XRAM_SIZE_RESET = 8'h0c;
	localparam int MSZC_RAM_LSB = 5;
	localparam int MSZC_ROM_LSB = 0;
	localparam int MSZC_XRAM_LSB = 0;
	localparam logic [7:0] MSZC_XRAM_MASK = 8'h1f;
	localparam logic [2:0] MSZC_RAM_768 = 3'h0;
	localparam logic [2:0] MSZC_RAM_1024 = 3'h6;
	localparam logic [3:0] MSZC_ROM_16K = 4'h4;
	localparam logic [3:0] MSZC_ROM_24K = 4'h6;
	localparam logic [3:0] MSZC_ROM_32K = 4'h8;
	localparam logic [3:0] MSZC_ROM_48K = 4'hc;
	localparam logic [3:0] MSZC_ROM_60K = 4'hf;
	localparam logic [4:0] MSZC_XRAM_0 = 5'h0c;
	localparam logic [4:0] MSZC_XRAM_1K = 5'h0a;
	localparam logic [4:0] MSZC_XRAM_2K = 5'h08;
	localparam logic [4:0] MSZC_XRAM_4K = 5'h04;
	localparam logic [4:0] MSZC_XRAM_6K = 5'h00;
	typedef enum logic [1:0] {MSZC_CLK_FAST_OSC, MSZC_CLK_CRYSTAL, MSZC_CLK_EXTERNAL} mszc_clk_t;
endpackage

// ---- core/mszc_decode.sv ----
`timescale 1ns/1ps
module mszc_decode
	import mszc_pkg::*;
(
	input wire logic [7:0] mem_size,
	input wire logic [7:0] xram_size,
	output logic [10:0] ram_bytes,
	output logic [6:0] rom_kb,
	output logic [12:0] xram_bytes,
	output logic prohibited
);
	logic ram_bad;
	logic rom_bad;
	logic xram_bad;
	always_comb begin
		ram_bad = 1'b0;
		rom_bad = 1'b0;
		xram_bad = 1'b0;
		case (mem_size[MSZC_RAM_LSB +: 3])
			MSZC_RAM_768: ram_bytes = 11'd768;
			MSZC_RAM_1024: ram_bytes = 11'd1024;
			default: begin
				ram_bytes = 11'd0;
				ram_bad = 1'b1;
			end
		endcase
		case (mem_size[MSZC_ROM_LSB +: 4])
			MSZC_ROM_16K: rom_kb = 7'd16;
			MSZC_ROM_24K: rom_kb = 7'd24;
			MSZC_ROM_32K: rom_kb = 7'd32;
			MSZC_ROM_48K: rom_kb = 7'd48;
			MSZC_ROM_60K: rom_kb = 7'd60;
			default: begin
				rom_kb = 7'd0;
				rom_bad = 1'b1;
			end
		endcase
		case (xram_size[MSZC_XRAM_LSB +: 5])
			MSZC_XRAM_0: xram_bytes = 13'd0;
			MSZC_XRAM_1K: xram_bytes = 13'd1024;
			MSZC_XRAM_2K: xram_bytes = 13'd2048;
			MSZC_XRAM_4K: xram_bytes = 13'd4096;
			MSZC_XRAM_6K: xram_bytes = 13'd6144;
			default: begin
				xram_bytes = 13'd0;
				xram_bad = 1'b1;
			end
		endcase
		// bit 4 of the size register is fixed zero; a one there is also a bad setting
		prohibited = ram_bad | rom_bad | xram_bad | mem_size[4];
	end
endmodule

// ---- core/mszc_regs.sv ----
`timescale 1ns/1ps
module mszc_regs
	import mszc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [15:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rd_hit,
	input wire logic program_mode_pin,
	input wire logic sel_async_serial_port,
	input wire logic ext_clock_present,
	output logic [7:0] memory_size_select,
	output logic [7:0] expansion_ram_size_select,
	output logic [10:0] hs_ram_bytes,
	output logic [6:0] rom_kbytes,
	output logic [12:0] xram_bytes,
	output logic size_prohibited,
	output logic flash_program_mode,
	output logic [1:0] clock_source
);
	typedef struct packed {
		logic [7:0] mem_reg;
		logic [7:0] xram_reg;
		logic [7:0] rdata_reg;
		logic hit_reg;
		logic [2:0] mode_sync_reg;
		logic mode_reg;
		logic [2:0] async_sync_reg;
		logic async_reg;
		logic [2:0] ext_sync_reg;
		logic ext_reg;
		logic [10:0] ram_reg;
		logic [6:0] rom_reg;
		logic [12:0] xbytes_reg;
		logic bad_reg;
		mszc_clk_t clk_reg;
	} mszc_state_t;

	mszc_state_t state_reg;
	mszc_state_t state_next;
	logic [10:0] dec_ram;
	logic [6:0] dec_rom;
	logic [12:0] dec_xram;
	logic dec_bad;

	////////////////////////////////////////////////////////////////
	mszc_decode u_decode (
		.mem_size(state_reg.mem_reg),
		.xram_size(state_reg.xram_reg),
		.ram_bytes(dec_ram),
		.rom_kb(dec_rom),
		.xram_bytes(dec_xram),
		.prohibited(dec_bad)
	);

	////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		if (wr_en && addr == MSZC_MEM_SIZE_ADDR) begin
			state_next.mem_reg = wdata;
		end
		// whole byte store, upper bits held zero
		if (wr_en && addr == MSZC_XRAM_SIZE_ADDR) begin
			state_next.xram_reg = wdata & MSZC_XRAM_MASK;
		end
		state_next.hit_reg = 1'b0;
		state_next.rdata_reg = 8'h00;
		if (rd_en && addr == MSZC_MEM_SIZE_ADDR) begin
			state_next.rdata_reg = state_reg.mem_reg;
			state_next.hit_reg = 1'b1;
		end else if (rd_en && addr == MSZC_XRAM_SIZE_ADDR) begin
			state_next.rdata_reg = state_reg.xram_reg;
			state_next.hit_reg = 1'b1;
		end
		// pins are asynchronous: three stages, act once the last two agree
		state_next.mode_sync_reg = {state_reg.mode_sync_reg[1:0], program_mode_pin};
		state_next.async_sync_reg = {state_reg.async_sync_reg[1:0], sel_async_serial_port};
		state_next.ext_sync_reg = {state_reg.ext_sync_reg[1:0], ext_clock_present};
		if (state_reg.mode_sync_reg[2] == state_reg.mode_sync_reg[1]) begin
			state_next.mode_reg = state_reg.mode_sync_reg[2];
		end
		if (state_reg.async_sync_reg[2] == state_reg.async_sync_reg[1]) begin
			state_next.async_reg = state_reg.async_sync_reg[2];
		end
		if (state_reg.ext_sync_reg[2] == state_reg.ext_sync_reg[1]) begin
			state_next.ext_reg = state_reg.ext_sync_reg[2];
		end
		if (!state_reg.mode_reg || !state_reg.async_reg) begin
			state_next.clk_reg = MSZC_CLK_FAST_OSC;
		// async link takes crystal or programmer clock
		end else if (state_reg.ext_reg) begin
			state_next.clk_reg = MSZC_CLK_EXTERNAL;
		end else begin
			state_next.clk_reg = MSZC_CLK_CRYSTAL;
		end
		state_next.ram_reg = dec_ram;
		state_next.rom_reg = dec_rom;
		state_next.xbytes_reg = dec_xram;
		state_next.bad_reg = dec_bad;
		if (reset) begin
			state_next = '0;
			state_next.mem_reg = MSZC_MEM_SIZE_RESET;
			state_next.xram_reg = MSZC_XRAM_SIZE_RESET;
			state_next.clk_reg = MSZC_CLK_FAST_OSC;
		end
	end

	always_ff @(posedge mclk) begin
		state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////
	assign rdata = state_reg.rdata_reg;
	assign rd_hit = state_reg.hit_reg;
	assign memory_size_select = state_reg.mem_reg;
	assign expansion_ram_size_select = state_reg.xram_reg;
	assign hs_ram_bytes = state_reg.ram_reg;
	assign rom_kbytes = state_reg.rom_reg;
	assign xram_bytes = state_reg.xbytes_reg;
	assign size_prohibited = state_reg.bad_reg;
	assign flash_program_mode = state_reg.mode_reg;
	assign clock_source = state_reg.clk_reg;
endmodule

// ---- verification/mszc_regs_sva.sv ----
`timescale 1ns/1ps
module mszc_regs_chk
	import mszc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [15:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rd_hit,
	input wire logic [7:0] memory_size_select,
	input wire logic [7:0] expansion_ram_size_select,
	input wire logic [6:0] rom_kbytes,
	input wire logic flash_program_mode,
	input wire logic [1:0] clock_source
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	mss_write_a: assert property (wr_en && addr == MSZC_MEM_SIZE_ADDR |=> memory_size_select == $past(wdata))
		else $error("size write lost");
	xrs_write_a: assert property (wr_en && addr == MSZC_XRAM_SIZE_ADDR |=>
		expansion_ram_size_select == ($past(wdata) & MSZC_XRAM_MASK)) else $error("xram write lost");
	reset_load_a: assert property ($past(reset) |-> memory_size_select == MSZC_MEM_SIZE_RESET &&
		expansion_ram_size_select == MSZC_XRAM_SIZE_RESET) else $error("bad reset value");
	rom_big_a: assert property (memory_size_select[3:0] == MSZC_ROM_48K |=> rom_kbytes == 7'd48)
		else $error("rom 48 decode");
	rom_small_a: assert property (memory_size_select[3:0] == MSZC_ROM_16K |=> rom_kbytes == 7'd16)
		else $error("rom 16 decode");
	read_hit_a: assert property (rd_en && addr == MSZC_XRAM_SIZE_ADDR |=>
		rd_hit && rdata == $past(expansion_ram_size_select)) else $error("xram read");
	read_miss_a: assert property (rd_en && addr != MSZC_MEM_SIZE_ADDR && addr != MSZC_XRAM_SIZE_ADDR |=>
		!rd_hit && rdata == 8'h00) else $error("unmapped read");
	size_hold_a: assert property (!wr_en |=> $stable(memory_size_select))
		else $error("size changed");
	xram_upper_a: assert property (expansion_ram_size_select[7:5] == 3'h0)
		else $error("xram upper bits set");
	osc_force_a: assert property (!flash_program_mode |=> clock_source == MSZC_CLK_FAST_OSC)
		else $error("clock source not internal");
endmodule
////////////////////////////////////////////////////////////////
bind mszc_regs mszc_regs_chk i_mszc_regs_chk (.mclk(mclk), .reset(reset), .addr(addr), .wr_en(wr_en),
	.rd_en(rd_en), .wdata(wdata), .rdata(rdata), .rd_hit(rd_hit), .memory_size_select(memory_size_select),
	.expansion_ram_size_select(expansion_ram_size_select), .rom_kbytes(rom_kbytes),
	.flash_program_mode(flash_program_mode), .clock_source(clock_source));

// ---- verification/test_mszc_regs.sv ----
`timescale 1ns/1ps
module test_mszc_regs
	import mszc_pkg::*;
;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic pm = 1'b0;
	logic asy = 1'b0;
	logic ext = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, mss, xrs;
	logic [10:0] hs;
	logic [6:0] rom;
	logic [12:0] xr;
	logic hit, bad, fpm;
	logic [1:0] cs;
	int n_errors = 0;
	int compares = 0;
	mszc_regs i_mszc_regs (.mclk(mclk), .reset(reset), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wdata(wdata), .rdata(rdata), .rd_hit(hit), .program_mode_pin(pm), .sel_async_serial_port(asy),
		.ext_clock_present(ext), .memory_size_select(mss), .expansion_ram_size_select(xrs),
		.hs_ram_bytes(hs), .rom_kbytes(rom), .xram_bytes(xr), .size_prohibited(bad),
		.flash_program_mode(fpm), .clock_source(cs));
	initial begin
		forever #4 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	// one-cycle strobe; extra cycle lets the decode land
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge mclk);
		wr_en = 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge mclk);
		addr = a;
		rd_en = 1'b1;
		@(negedge mclk);
		rd_en = 1'b0;
		chk(rdata, e);
		chk(hit, a == MSZC_MEM_SIZE_ADDR || a == MSZC_XRAM_SIZE_ADDR);
	endtask
	task automatic pins(input logic p, input logic a, input logic x);
		pm = p;
		asy = a;
		ext = x;
		repeat (7) @(negedge mclk);
	endtask
	task automatic wrap_up();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(MSZC_MEM_SIZE_ADDR, 8'hcf);
		rd(MSZC_XRAM_SIZE_ADDR, 8'h0c);
		chk(hs, 16'd1024);
		chk(rom, 16'd60);
		chk(xr, 16'd0);
		chk(mss, 16'h00cf);
		chk(xrs, 16'h000c);
		chk(bad, 1'b0);
		$display("t_reset done");
	endtask
	task automatic t_codes();
		// big rom pairs with small xram and rom shrinks before xram grows
		logic [3:0] rc [5] = '{4'hf, 4'hc, 4'h8, 4'h6, 4'h4};
		logic [15:0] rk [5] = '{16'd60, 16'd48, 16'd32, 16'd24, 16'd16};
		logic [4:0] xc [5] = '{5'h0c, 5'h0a, 5'h08, 5'h04, 5'h00};
		logic [15:0] xk [5] = '{16'd0, 16'd1024, 16'd2048, 16'd4096, 16'd6144};
		// both registers programmed after release
		for (int i = 0; i < 5; i++) begin
			// size register first, expansion after
			wr(MSZC_MEM_SIZE_ADDR, {4'h0, rc[i]});
			chk(rom, rk[i]);
			chk(hs, 16'd768);
			wr(MSZC_XRAM_SIZE_ADDR, {3'h0, xc[i]});
			chk(xr, xk[i]);
			chk(bad, 1'b0);
		end
		wr(MSZC_MEM_SIZE_ADDR, 8'hcc);
		chk(hs, 16'd1024);
		chk(rom, 16'd48);
		chk(mss, 16'h00cc);
		$display("t_codes done");
	endtask
	task automatic t_misc();
		// expansion field still legal here, so the flag comes from the size register alone
		wr(MSZC_MEM_SIZE_ADDR, 8'h35);
		rd(MSZC_MEM_SIZE_ADDR, 8'h35);
		chk(bad, 1'b1);
		wr(MSZC_XRAM_SIZE_ADDR, 8'hff);
		rd(MSZC_XRAM_SIZE_ADDR, 8'h1f);
		chk(xrs, 16'h001f);
		wr(16'hfff2, 8'h00);
		rd(16'hfff1, 8'h00);
		rd(MSZC_MEM_SIZE_ADDR, 8'h35);
		rd(MSZC_XRAM_SIZE_ADDR, 8'h1f);
		$display("t_misc done");
	endtask
	task automatic t_rerun();
		@(negedge mclk);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		chk(mss, 16'h00cf);
		chk(xrs, 16'h000c);
		rd(MSZC_MEM_SIZE_ADDR, 8'hcf);
		rd(MSZC_XRAM_SIZE_ADDR, 8'h0c);
		chk(hs, 16'd1024);
		chk(bad, 1'b0);
		$display("t_rerun done");
	endtask
	task automatic t_pins();
		// same pin sequence serves on board or in an adapter
		pins(1'b1, 1'b0, 1'b1);
		chk(fpm, 1'b1);
		chk(cs, MSZC_CLK_FAST_OSC);
		pins(1'b1, 1'b1, 1'b1);
		chk(cs, MSZC_CLK_EXTERNAL);
		pins(1'b1, 1'b1, 1'b0);
		chk(cs, MSZC_CLK_CRYSTAL);
		pins(1'b0, 1'b1, 1'b0);
		chk(fpm, 1'b0);
		chk(cs, MSZC_CLK_FAST_OSC);
		$display("t_pins done");
	endtask
	initial begin
		repeat (12) @(negedge mclk);
		reset = 1'b0;
		t_reset();
		t_codes();
		t_misc();
		t_rerun();
		t_pins();
		wrap_up();
	end
	// whole run is about a hundred cycles
	initial begin
		#20000;
		n_errors++;
		$display("[ERR] %0t timeout", $time);
		wrap_up();
	end
endmodule
